// ==== pkg/utopia_phy_defs.svh ====
// Constants of the PHY-side cell port: addresses, thresholds.
// Assumes inclusion by the package and the design file only.
`ifndef UTOPIA_PHY_DEFS_SVH
`define UTOPIA_PHY_DEFS_SVH

// ----------------------------------------
// Port addressing
// ----------------------------------------
`define ADDR_W        5
`define NULL_PORT     5'h1F

// ----------------------------------------
// Bus widths
// ----------------------------------------
`define WORD_W        16
`define LOW_OCTET_W   8

// ----------------------------------------
// Flow control
// ----------------------------------------
`define WRITE_MARGIN  4
`define FIFO_DEPTH    8

`endif

// ==== pkg/utopia_phy_pkg.sv ====
// Types shared by the cell port and its testbench.
// Assumes the defs header sits on the include path.
`include "utopia_phy_defs.svh"

package utopia_phy_pkg;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic                 soc;
    logic [`WORD_W-1:0]   data;
  } cellWord_s;

  // ----------------------------------------
  // Receive selection
  // ----------------------------------------
  typedef enum logic {
    RX_IDLE,
    RX_SEL
  } rxSel_e;

endpackage : utopia_phy_pkg

// ==== rtl/utopia_l2_phy_cell_port.sv ====
// PHY-side multi-PHY cell port with transmit FIFO and receive output stage.
// Assumes both link clocks come from the ATM layer, far slower than clk_sys.
`timescale 1ns/1ns
`include "utopia_phy_defs.svh"

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module cell_word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic [WIDTH-1:0]         inData,
  input  wire logic                     inValid,
  output logic                          inReady,
  output logic [WIDTH-1:0]              outData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic [$clog2(DEPTH+1)-1:0]    fill
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : badDepth
    $error("FIFO depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0]           mem [DEPTH];
  logic [PW-1:0]              wrPtr_q;
  logic [PW-1:0]              rdPtr_q;
  logic [$clog2(DEPTH+1)-1:0] count_q;
  logic                       push;
  logic                       pop;

  assign inReady  = (count_q != ($clog2(DEPTH+1))'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign fill     = count_q;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : cell_word_fifo

// What this block does
// - Octet mode: space indicator goes low when four or fewer writes remain.
// - Cell mode: space indicator driven only the cycle after own address seen.
// - Polled answer is high when a whole cell fits, else low.
// - Cell mode: space indicator floats whenever not answering own poll.
// - Receive strobe low means data and start flag sampled next cycle end.
// - Receive data and start flag drive only after a strobed cycle.
// - Five-bit port address, bit 4 top; in cell mode address 31 is never answered.
// - In cell mode the port answers only on its own address; it is selected for receive only on its own address; writes are taken at any address.
// - Receive bus carries high octet MSB on bit 15, low on bit 7.
// - Transmit data checked for odd parity, low byte or all 16 bits.
// - Receive parity is odd over low byte or 16 bits, floats like data.
module utopia_l2_phy_cell_port
  import utopia_phy_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic [`ADDR_W-1:0]  phyAddr,
  input  wire logic                cellMode,
  input  wire logic                wide16,
  input  wire logic                tx_byte_clock,
  input  wire logic                tx_write_strobe_n,
  input  wire logic [`ADDR_W-1:0]  tx_port_select,
  input  wire logic [`WORD_W-1:0]  tx_word_bus,
  input  wire logic                tx_cell_first_flag,
  input  wire logic                tx_parity_in,
  output logic                     tx_space_indicator,
  output logic                     tx_space_indicator_oe,
  output cellWord_s                txOut,
  output logic                     txOutValid,
  input  wire logic                txOutReady,
  input  wire logic                txCellRoom,
  output logic                     txParityErr,
  output logic                     txOverrun,
  input  wire logic                rx_byte_clock,
  input  wire logic                rx_read_strobe_n,
  input  wire logic [`ADDR_W-1:0]  rx_port_select,
  output logic [`WORD_W-1:0]       rx_word_bus,
  output logic                     rx_word_bus_oe,
  output logic                     rx_cell_first_flag,
  output logic                     rx_cell_first_flag_oe,
  output logic                     rx_parity_out,
  output logic                     rx_parity_out_oe,
  output logic                     rxCellAvail,
  output logic                     rxCellAvail_oe,
  input  cellWord_s                rxIn,
  input  wire logic                rxInValid,
  output logic                     rxInReady,
  input  wire logic                rxCellReady
);
  localparam int TXW = 1 + 1 + `ADDR_W + `WORD_W + 1 + 1;
  localparam int RXW = 1 + 1 + `ADDR_W;
  localparam int FW  = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH <= `WRITE_MARGIN) begin : badFifo
    $error("FIFO must be deeper than the write margin");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Whole pin groups pass two stages together, so clock and data keep their
  // relative timing; the link clock is slow enough for that to hold.
  logic [TXW-1:0] txS1_q;
  logic [TXW-1:0] txS2_q;
  logic [RXW-1:0] rxS1_q;
  logic [RXW-1:0] rxS2_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      txS1_q <= {2'b01, {(TXW-2){1'b0}}};
      txS2_q <= {2'b01, {(TXW-2){1'b0}}};
      rxS1_q <= {2'b01, {(RXW-2){1'b0}}};
      rxS2_q <= {2'b01, {(RXW-2){1'b0}}};
    end else begin
      txS1_q <= {tx_byte_clock, tx_write_strobe_n, tx_port_select,
                 tx_word_bus, tx_cell_first_flag, tx_parity_in};
      txS2_q <= txS1_q;
      rxS1_q <= {rx_byte_clock, rx_read_strobe_n, rx_port_select};
      rxS2_q <= rxS1_q;
    end
  end

  logic               txClk;
  logic               txEnbN;
  logic [`ADDR_W-1:0] txAddr;
  logic [`WORD_W-1:0] txData;
  logic               txSoc;
  logic               txPar;
  logic               rxClk;
  logic               rxEnbN;
  logic [`ADDR_W-1:0] rxAddr;

  assign {txClk, txEnbN, txAddr, txData, txSoc, txPar} = txS2_q;
  assign {rxClk, rxEnbN, rxAddr} = rxS2_q;

  // ----------------------------------------
  // Link clock edges
  // ----------------------------------------
  logic txClkPrev_q;
  logic rxClkPrev_q;
  logic txRise;
  logic rxRise;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      txClkPrev_q <= 1'b0;
      rxClkPrev_q <= 1'b0;
    end else begin
      txClkPrev_q <= txClk;
      rxClkPrev_q <= rxClk;
    end
  end

  assign txRise = txClk && !txClkPrev_q;
  assign rxRise = rxClk && !rxClkPrev_q;

  // ----------------------------------------
  // Transmit write path
  // ----------------------------------------
  logic      txWrite;
  logic      txFifoReady;
  logic      txParGood;
  logic [FW-1:0] txFill;
  logic [FW-1:0] txFree;
  cellWord_s txWord;

  // Start flag is taken as given; the far side places it on the first word.
  assign txWord.soc  = txSoc;
  assign txWord.data = txData;
  assign txWrite     = txRise && !txEnbN;
  // Room left once this edge's write lands, so the margin is never overstated
  assign txFree      = FW'(FIFO_DEPTH) - txFill - FW'(txWrite && txFifoReady);
  assign txParGood   = wide16 ? ^{txData, txPar}
                              : ^{txData[`LOW_OCTET_W-1:0], txPar};

  cell_word_fifo #(
    .WIDTH ($bits(cellWord_s)),
    .DEPTH (FIFO_DEPTH)
  ) txFifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .inData   (txWord),
    .inValid  (txWrite),
    .inReady  (txFifoReady),
    .outData  (txOut),
    .outValid (txOutValid),
    .outReady (txOutReady),
    .fill     (txFill)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      txParityErr <= 1'b0;
      txOverrun   <= 1'b0;
    end else begin
      txParityErr <= txWrite && !txParGood;
      // Writes into a full FIFO are dropped; the pulse tells the user why
      txOverrun   <= txWrite && !txFifoReady;
    end
  end

  // ----------------------------------------
  // Transmit space indicator
  // ----------------------------------------
  logic txHit;

  assign txHit = (txAddr == phyAddr) && (txAddr != `NULL_PORT);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_space_indicator    <= 1'b1;
      tx_space_indicator_oe <= 1'b0;
    end else if (txRise) begin
      if (cellMode) begin
        tx_space_indicator_oe <= txHit;
        tx_space_indicator    <= txCellRoom &&
                                 (txFree > FW'(`WRITE_MARGIN));
      end else begin
        tx_space_indicator_oe <= 1'b1;
        tx_space_indicator    <= (txFree > FW'(`WRITE_MARGIN));
      end
    end
  end

  // ----------------------------------------
  // Receive selection
  // ----------------------------------------
  rxSel_e rxSel_q;
  logic   rxEnbPrev_q;
  logic   rxHit;
  logic   rxSelNow;

  assign rxHit = (rxAddr == phyAddr) && (rxAddr != `NULL_PORT);
  // Selection is latched on the strobe's falling edge and kept while low
  assign rxSelNow  = !rxEnbN && (rxEnbPrev_q ? rxHit : (rxSel_q == RX_SEL));
  assign rxInReady = rxRise && rxSelNow;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rxSel_q     <= RX_IDLE;
      rxEnbPrev_q <= 1'b1;
    end else if (rxRise) begin
      rxEnbPrev_q <= rxEnbN;
      if (!rxEnbN && rxEnbPrev_q) begin
        rxSel_q <= rxHit ? RX_SEL : RX_IDLE;
      end
    end
  end

  // ----------------------------------------
  // Receive output stage
  // ----------------------------------------
  logic [`WORD_W-1:0] rxWord;

  // Narrow mode keeps the unused high octet at zero
  assign rxWord = wide16 ? rxIn.data
                         : {{(`WORD_W-`LOW_OCTET_W){1'b0}},
                            rxIn.data[`LOW_OCTET_W-1:0]};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_word_bus        <= '0;
      rx_cell_first_flag <= 1'b0;
      rx_parity_out      <= 1'b1;
    end else if (rxRise && rxSelNow) begin
      if (rxInValid) begin
        rx_word_bus        <= rxWord;
        rx_cell_first_flag <= rxIn.soc;
        rx_parity_out      <= ~^rxWord;
      end else begin
        // No word ready: the previous word stays, with the start flag down
        rx_cell_first_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_word_bus_oe        <= 1'b0;
      rx_cell_first_flag_oe <= 1'b0;
      rx_parity_out_oe      <= 1'b0;
    end else if (rxRise) begin
      rx_word_bus_oe        <= rxSelNow;
      rx_cell_first_flag_oe <= rxSelNow;
      rx_parity_out_oe      <= rxSelNow;
    end
  end

  // ----------------------------------------
  // Receive cell available
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rxCellAvail    <= 1'b0;
      rxCellAvail_oe <= 1'b0;
    end else if (rxRise) begin
      if (cellMode) begin
        rxCellAvail_oe <= rxHit;
        rxCellAvail    <= rxCellReady;
      end else begin
        // Active high: low means nothing to deliver this cycle
        rxCellAvail_oe <= 1'b1;
        rxCellAvail    <= rxInValid;
      end
    end
  end

endmodule : utopia_l2_phy_cell_port

// ==== bench/cell_port_props.sv ====
// Checker for the cell port, bound to its top module.
// Assumes link clocks many clk_sys cycles long.
`timescale 1ns/1ns
module cell_port_props
  import utopia_phy_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [4:0]  phyAddr,
  input wire logic        cellMode,
  input wire logic        wide16,
  input wire logic [4:0]  tx_port_select,
  input wire logic        txCellRoom,
  input wire logic        tx_space_indicator,
  input wire logic        tx_space_indicator_oe,
  input wire logic        txOutValid,
  input wire logic [15:0] rx_word_bus,
  input wire logic        rx_word_bus_oe,
  input wire logic        rx_cell_first_flag,
  input wire logic        rx_cell_first_flag_oe,
  input wire logic        rx_parity_out,
  input wire logic        rx_parity_out_oe,
  input wire cellWord_s   rxIn,
  input wire logic        rxInValid,
  input wire logic        rxInReady
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  rx_oe_group_a: assert property (rx_word_bus_oe == rx_cell_first_flag_oe && rx_word_bus_oe == rx_parity_out_oe)
    else $error("rx enables split");
  rx_ready_a: assert property (rxInReady && rxInValid |=> rx_word_bus_oe
    && rx_cell_first_flag == $past(rxIn.soc) && rx_word_bus[7:0] == $past(rxIn.data[7:0]))
    else $error("rx word not presented");
  rx_stand_a: assert property ($rose(rx_word_bus_oe) |=> rx_word_bus_oe [*8])
    else $error("rx enable too short");
  rx_parity_a: assert property (rx_parity_out_oe |-> ^{rx_parity_out, rx_word_bus[7:0],
    wide16 ? rx_word_bus[15:8] : 8'h00})
    else $error("rx parity not odd");
  rx_upper_a: assert property (rx_word_bus_oe && !wide16 |-> rx_word_bus[15:8] == 8'h00)
    else $error("rx upper byte set");
  tx_octet_oe_a: assert property (!cellMode && txOutValid |-> tx_space_indicator_oe)
    else $error("octet indicator floats");
  tx_octet_level_a: assert property (!cellMode && $fell(tx_space_indicator) |-> txOutValid)
    else $error("octet indicator low when empty");
  tx_poll_addr_a: assert property (cellMode && $rose(tx_space_indicator_oe)
    |-> $past(tx_port_select, 4) == phyAddr && phyAddr != 5'h1F)
    else $error("poll answer without own address");
  tx_room_a: assert property (cellMode && $rose(tx_space_indicator_oe) && !$past(txCellRoom) |-> !tx_space_indicator)
    else $error("poll answer high without room");
endmodule : cell_port_props

bind utopia_l2_phy_cell_port cell_port_props props (.*);

// ==== bench/atm_layer_model.sv ====
// Far-side model: makes both link clocks and drives the link pins.
// Assumes one task call at a time; clocks stand still between calls.
`timescale 1ns/1ns
module atm_layer_model (
  output logic        tx_byte_clock,
  output logic        tx_write_strobe_n,
  output logic [4:0]  tx_port_select,
  output logic [15:0] tx_word_bus,
  output logic        tx_cell_first_flag,
  output logic        tx_parity_in,
  output logic        rx_byte_clock,
  output logic        rx_read_strobe_n,
  output logic [4:0]  rx_port_select
);
  // ----------------------------------------
  // Link cycles
  // ----------------------------------------
  initial begin
    {tx_byte_clock, tx_write_strobe_n, tx_port_select, tx_word_bus} = {2'b01, 5'h1F, 16'h0000};
    {tx_cell_first_flag, tx_parity_in} = 2'b01;
    {rx_byte_clock, rx_read_strobe_n, rx_port_select} = {2'b01, 5'h1F};
  end
  // Pins change mid-cycle, far from the sampling edge
  task automatic txCycle(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic s, input logic bad);
    #3;
    tx_write_strobe_n = !wr;
    tx_port_select = a;
    tx_word_bus = wr ? d : ~tx_word_bus;
    tx_cell_first_flag = wr & s;
    tx_parity_in = ~^d ^ bad;
    #80 tx_byte_clock = 1'b1;
    #74 tx_byte_clock = 1'b0;
    // 160 ns per call keeps pin changes off the clk_sys edges
    #3;
  endtask : txCycle
  task automatic rxCycle(input logic rd, input logic [4:0] a);
    #3;
    rx_read_strobe_n = !rd;
    rx_port_select = a;
    #80 rx_byte_clock = 1'b1;
    #74 rx_byte_clock = 1'b0;
    #3;
  endtask : rxCycle
endmodule : atm_layer_model

// ==== bench/tb.sv ====
// Self-checking bench for the cell port.
// Assumes the package, design, checker and far-side model are compiled first.
`timescale 1ns/1ns
module tb
  import utopia_phy_pkg::*;
;
  logic clk_sys = 0, rstn = 0, cellMode = 0, wide16 = 1, txOutReady = 0, txCellRoom = 1;
  logic rxInValid = 0, rxCellReady = 0;
  logic [4:0] phyAddr = 5'h03, tx_port_select, rx_port_select;
  logic tx_byte_clock, tx_write_strobe_n, tx_cell_first_flag, tx_parity_in, rx_byte_clock, rx_read_strobe_n;
  logic [15:0] tx_word_bus, rx_word_bus;
  logic tx_space_indicator, tx_space_indicator_oe, txOutValid, txParityErr, txOverrun, rx_word_bus_oe;
  logic rx_cell_first_flag, rx_cell_first_flag_oe, rx_parity_out, rx_parity_out_oe;
  logic rxCellAvail, rxCellAvail_oe, rxInReady;
  logic [3:0] perrN = 0, ovrN = 0;
  cellWord_s txOut;
  cellWord_s rxIn = 17'h1A5C3;
  int nFail = 0, checksDone = 0, cyc = 0;

  utopia_l2_phy_cell_port dut (.*);
  atm_layer_model atm (.*);

  always #5 clk_sys = ~clk_sys;
  // Pulses are one cycle wide, so count them as they pass
  always @(posedge clk_sys) begin
    if (rxInReady && rxInValid) rxIn <= 17'h05A3C;
    if (txParityErr) perrN <= perrN + 4'h1;
    if (txOverrun) ovrN <= ovrN + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nFail++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [16:0] got, input logic [16:0] exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tTxOctet;
    for (int k = 0; k < 9; k++) begin
      atm.txCycle(1'b1, phyAddr, 16'h1000 + 16'(k), k == 0, k == 2);
      if (k < 8) chk("space", tx_space_indicator, 17'(7 - k > 4));
    end
    chk("perr", perrN, 17'h1);
    chk("ovr", ovrN, 17'h1);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      chk("head", txOut, {k == 0, 16'h1000 + 16'(k)});
      txOutReady <= 1'b1;
      @(posedge clk_sys);
      txOutReady <= 1'b0;
    end
    @(posedge clk_sys);
    chk("empty", txOutValid, 17'h0);
  endtask : tTxOctet

  task automatic tTxPoll;
    @(posedge clk_sys);
    cellMode <= 1'b1;
    atm.txCycle(1'b0, phyAddr, 16'h0000, 1'b0, 1'b0);
    chk("poll", {tx_space_indicator_oe, tx_space_indicator}, 17'h3);
    atm.txCycle(1'b0, 5'h1F, 16'h0000, 1'b0, 1'b0);
    chk("null", tx_space_indicator_oe, 17'h0);
    @(posedge clk_sys);
    txCellRoom <= 1'b0;
    atm.txCycle(1'b0, phyAddr, 16'h0000, 1'b0, 1'b0);
    chk("noroom", {tx_space_indicator_oe, tx_space_indicator}, 17'h2);
    atm.txCycle(1'b0, 5'h07, 16'h0000, 1'b0, 1'b0);
    chk("other", tx_space_indicator_oe, 17'h0);
  endtask : tTxPoll

  task automatic tRx;
    @(posedge clk_sys);
    rxCellReady <= 1'b1;
    rxInValid <= 1'b1;
    atm.rxCycle(1'b0, phyAddr);
    chk("avail", {rxCellAvail_oe, rxCellAvail}, 17'h3);
    atm.rxCycle(1'b1, phyAddr);
    chk("w0", {rx_cell_first_flag, rx_word_bus}, 17'h1A5C3);
    chk("p0", {rx_word_bus_oe, rx_parity_out}, {16'h0001, ~^16'hA5C3});
    atm.rxCycle(1'b0, 5'h1F);
    chk("off", {rx_word_bus_oe, rxCellAvail_oe}, 17'h0);
    @(posedge clk_sys);
    wide16 <= 1'b0;
    atm.rxCycle(1'b1, phyAddr);
    chk("w1", {rx_cell_first_flag, rx_word_bus}, 17'h0003C);
    chk("p1", rx_parity_out, {16'h0000, ~^8'h3C});
    atm.rxCycle(1'b0, phyAddr);
    @(posedge clk_sys);
    phyAddr <= 5'h1F;
    atm.rxCycle(1'b0, 5'h1F);
    atm.rxCycle(1'b1, 5'h1F);
    chk("nullsel", {rx_word_bus_oe, rxCellAvail_oe}, 17'h0);
  endtask : tRx

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    tTxOctet();
    tTxPoll();
    tRx();
    print_verdict();
  end
endmodule : tb
